/* File: srsr_pkg.sv */
package srsr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] SRSR_OFF_LOW  = 4'h8;
  localparam logic [3:0] SRSR_OFF_HIGH = 4'h9;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SRSR_BIT_POR    = 7;
  localparam int SRSR_BIT_PIN    = 6;
  localparam int SRSR_BIT_WDOG   = 5;
  localparam int SRSR_BIT_LVD    = 1;
  localparam int SRSR_BIT_WAKEUP = 0;
  localparam int SRSR_BIT_SACK   = 5;
  localparam int SRSR_BIT_DBG    = 3;
  localparam int SRSR_BIT_SW     = 2;
  localparam int SRSR_BIT_LOCKUP = 1;

  // ----------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------
  localparam logic [7:0] SRSR_LOW_MASK   = 8'hE3;
  localparam logic [7:0] SRSR_HIGH_MASK  = 8'h2E;
  localparam logic [7:0] SRSR_LOW_RESET  = 8'h82;
  localparam logic [7:0] SRSR_HIGH_RESET = 8'h00;

  // ----------------------------------------
  // Power modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRSR_MODE_RUN  = 3'h1,
    SRSR_MODE_LLS  = 3'h2,
    SRSR_MODE_VLLS = 3'h4
  } srsr_mode_t;

endpackage

/* File: srsr_cause.sv */
`timescale 1ns/1ns
module srsr_cause (
  input  wire logic       pin_reset_event,
  input  wire logic       wdog_reset_event,
  input  wire logic       wdog_enable,
  input  wire logic       lvd_trip_event,
  input  wire logic       low_voltage_reset_enable,
  input  wire logic       wakeup_event,
  input  wire logic       wakeup_from_pin,
  input  wire logic [2:0] power_mode,
  input  wire logic       stop_ack_timeout_event,
  input  wire logic       debugger_reset_event,
  input  wire logic       core_reset_request,
  input  wire logic       core_lockup_event,
  output logic      [7:0] low_set,
  output logic      [7:0] high_set,
  output logic            restart
);
  logic wake_ok;
  logic lvd_ok;

  always_comb begin
    wake_ok = 1'b0;
    if (power_mode == srsr_pkg::SRSR_MODE_LLS) begin
      wake_ok = wakeup_event & wakeup_from_pin;
    end else if (power_mode == srsr_pkg::SRSR_MODE_VLLS) begin
      wake_ok = wakeup_event;
    end
    lvd_ok = lvd_trip_event & low_voltage_reset_enable;
    low_set = 8'h00;
    high_set = 8'h00;
    low_set[srsr_pkg::SRSR_BIT_PIN]    = pin_reset_event;
    low_set[srsr_pkg::SRSR_BIT_WDOG]   = wdog_reset_event & wdog_enable;
    low_set[srsr_pkg::SRSR_BIT_LVD]    = lvd_ok;
    low_set[srsr_pkg::SRSR_BIT_WAKEUP] = wake_ok;
    high_set[srsr_pkg::SRSR_BIT_SACK]   = stop_ack_timeout_event;
    high_set[srsr_pkg::SRSR_BIT_DBG]    = debugger_reset_event;
    high_set[srsr_pkg::SRSR_BIT_SW]     = core_reset_request;
    high_set[srsr_pkg::SRSR_BIT_LOCKUP] = core_lockup_event;
    // Deep-wakeup from VLLS restarts history; an enabled LOW_VOLTAGE_DETECT trip restarts it too
    restart = lvd_ok | (wake_ok & (power_mode == srsr_pkg::SRSR_MODE_VLLS));
  end
endmodule

/* File: srsr_top.sv */
`timescale 1ns/1ns
module srsr_top (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       por_event,
  input  wire logic       pin_reset_event,
  input  wire logic       wdog_reset_event,
  input  wire logic       wdog_enable,
  input  wire logic       lvd_trip_event,
  input  wire logic       low_voltage_reset_enable,
  input  wire logic       wakeup_event,
  input  wire logic       wakeup_from_pin,
  input  wire logic [2:0] power_mode,
  input  wire logic       stop_ack_timeout_event,
  input  wire logic       debugger_reset_event,
  input  wire logic       core_reset_request,
  input  wire logic       core_lockup_event,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata
);
  logic [7:0] low_reg;
  logic [7:0] low_next;
  logic [7:0] high_reg;
  logic [7:0] high_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] low_set;
  logic [7:0] high_set;
  logic       restart;

  srsr_cause u_cause (
    .pin_reset_event          (pin_reset_event),
    .wdog_reset_event         (wdog_reset_event),
    .wdog_enable              (wdog_enable),
    .lvd_trip_event           (lvd_trip_event),
    .low_voltage_reset_enable (low_voltage_reset_enable),
    .wakeup_event             (wakeup_event),
    .wakeup_from_pin          (wakeup_from_pin),
    .power_mode               (power_mode),
    .stop_ack_timeout_event   (stop_ack_timeout_event),
    .debugger_reset_event     (debugger_reset_event),
    .core_reset_request       (core_reset_request),
    .core_lockup_event        (core_lockup_event),
    .low_set                  (low_set),
    .high_set                 (high_set),
    .restart                  (restart)
  );

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    if (reg_write && reg_addr == srsr_pkg::SRSR_OFF_LOW) begin
      low_next = low_reg & ~reg_wdata;
    end else if (reg_write && reg_addr == srsr_pkg::SRSR_OFF_HIGH) begin
      high_next = high_reg & ~reg_wdata;
    end
    if (por_event) begin
      // Supply was still ramping, so the low-voltage flag joins in
      low_next = srsr_pkg::SRSR_LOW_RESET;
      high_next = srsr_pkg::SRSR_HIGH_RESET;
    end else if (restart) begin
      low_next = low_set;
      high_next = high_set;
    end else begin
      low_next = low_next | low_set;
      high_next = high_next | high_set;
    end
    low_next = low_next & srsr_pkg::SRSR_LOW_MASK;
    high_next = high_next & srsr_pkg::SRSR_HIGH_MASK;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (reg_read && reg_addr == srsr_pkg::SRSR_OFF_LOW) begin
      rdata_next = low_reg;
    end else if (reg_read && reg_addr == srsr_pkg::SRSR_OFF_HIGH) begin
      rdata_next = high_reg;
    end
  end

  // Power-on state is taken on async reset as well
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_reg <= srsr_pkg::SRSR_LOW_RESET;
      high_reg <= srsr_pkg::SRSR_HIGH_RESET;
      rdata_reg <= 8'h00;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_pin_sets: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_reset_event && !por_event) |=> low_reg[srsr_pkg::SRSR_BIT_PIN])
    else $error("pin flag not set");
  chk_wdog_blocked: assert property (@(posedge clk_sys) disable iff (rst)
    (!wdog_enable && !por_event && !restart && !$past(low_reg[srsr_pkg::SRSR_BIT_WDOG])
     && !low_reg[srsr_pkg::SRSR_BIT_WDOG]) |=> !low_reg[srsr_pkg::SRSR_BIT_WDOG])
    else $error("watchdog flag set while disabled");
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    ((low_reg & ~srsr_pkg::SRSR_LOW_MASK) == 8'h00) && ((high_reg & ~srsr_pkg::SRSR_HIGH_MASK) == 8'h00))
    else $error("reserved bit set");
  chk_por_lvd: assert property (@(posedge clk_sys) disable iff (rst)
    por_event |=> low_reg[srsr_pkg::SRSR_BIT_LVD] && low_reg[srsr_pkg::SRSR_BIT_POR])
    else $error("power-on did not set flags");
  chk_lls_pin_only: assert property (@(posedge clk_sys) disable iff (rst)
    (power_mode == srsr_pkg::SRSR_MODE_LLS && !wakeup_from_pin && !por_event
     && !low_reg[0]) |=> !low_reg[srsr_pkg::SRSR_BIT_WAKEUP])
    else $error("non-pin wakeup in low-leakage stop");
  chk_w1c_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_write && reg_addr == srsr_pkg::SRSR_OFF_HIGH && !por_event && !restart
     && high_set == 8'h00) |=> ((high_reg & $past(reg_wdata)) == 8'h00))
    else $error("write one did not clear");
  chk_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    (core_lockup_event && !por_event) |=> high_reg[srsr_pkg::SRSR_BIT_LOCKUP])
    else $error("clear beat a new set");
  chk_read_data: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_read && reg_addr == srsr_pkg::SRSR_OFF_LOW) |=> reg_rdata == $past(low_reg))
    else $error("read data wrong");
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic       clk_sys;
  logic       rst;
  logic [8:0] ev;
  logic       wdog_en;
  logic       lv_en;
  logic       wk_pin;
  logic [2:0] mode;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  int         failures;
  int         compares;

  srsr_top dut_u (.clk_sys(clk_sys), .rst(rst), .por_event(ev[8]), .pin_reset_event(ev[0]),
    .wdog_reset_event(ev[1]), .wdog_enable(wdog_en), .lvd_trip_event(ev[2]), .low_voltage_reset_enable(lv_en),
    .wakeup_event(ev[3]), .wakeup_from_pin(wk_pin), .power_mode(mode), .stop_ack_timeout_event(ev[4]),
    .debugger_reset_event(ev[5]), .core_reset_request(ev[6]), .core_lockup_event(ev[7]),
    .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Bus and event helpers
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk_sys);
    wr_s  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1;
    compares++;
    if ((rdata & m) !== exp) begin
      failures++;
      $display("unexpected at %0t: addr %h got %h expected %h", $time, a, rdata & m, exp);
    end
  endtask

  task automatic pulse(input logic [8:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 9'h000;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(4'h8, 8'hFF, 8'h82);
    rdc(4'h9, 8'hFF, 8'h00);
    wr(4'h3, 8'hFF);
    rdc(4'h3, 8'hFF, 8'h00);
    rdc(4'h8, 8'hFF, 8'h82);
    $display("t_reset done");
  endtask

  task automatic t_sources();
    wdog_en <= 1'b1;
    pulse(9'h0F3);
    rdc(4'h8, 8'hFF, 8'hE2);
    rdc(4'h9, 8'hFF, 8'h2E);
    $display("t_sources done");
  endtask

  task automatic t_clear();
    wr(4'h8, 8'h40);
    rdc(4'h8, 8'hFF, 8'hA2);
    wr(4'h8, 8'h00);
    rdc(4'h8, 8'hFF, 8'hA2);
    wr(4'h9, 8'hF4);
    rdc(4'h9, 8'hFF, 8'h0A);
    // Pin cause lands in the same cycle as its own clear
    @(posedge clk_sys);
    ev    <= 9'h001;
    addr  <= 4'h8;
    wdata <= 8'h40;
    wr_s  <= 1'b1;
    @(posedge clk_sys);
    ev    <= 9'h000;
    wr_s  <= 1'b0;
    rdc(4'h8, 8'hFF, 8'hE2);
    $display("t_clear done");
  endtask

  task automatic t_gated();
    wr(4'h8, 8'hFF);
    wdog_en <= 1'b0;
    lv_en   <= 1'b0;
    pulse(9'h006);
    rdc(4'h8, 8'hFF, 8'h00);
    lv_en <= 1'b1;
    pulse(9'h004);
    rdc(4'h8, 8'hFF, 8'h02);
    rdc(4'h9, 8'hFF, 8'h00);
    $display("t_gated done");
  endtask

  task automatic t_wake();
    mode   <= srsr_pkg::SRSR_MODE_LLS;
    wk_pin <= 1'b0;
    pulse(9'h008);
    rdc(4'h8, 8'h01, 8'h00);
    wk_pin <= 1'b1;
    pulse(9'h008);
    rdc(4'h8, 8'h01, 8'h01);
    pulse(9'h080);
    mode   <= srsr_pkg::SRSR_MODE_VLLS;
    wk_pin <= 1'b0;
    pulse(9'h008);
    rdc(4'h8, 8'hFF, 8'h01);
    rdc(4'h9, 8'hFF, 8'h00);
    pulse(9'h100);
    rdc(4'h8, 8'hFF, 8'h82);
    $display("t_wake done");
  endtask

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    compares = 0;
    rst      = 1'b1;
    ev       = 9'h000;
    wdog_en  = 1'b0;
    lv_en    = 1'b0;
    wk_pin   = 1'b0;
    mode     = srsr_pkg::SRSR_MODE_RUN;
    addr     = 4'h0;
    wdata    = 8'h00;
    wr_s     = 1'b0;
    rd_s     = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_sources();
    t_clear();
    t_gated();
    t_wake();
    test_done();
  end
endmodule
